// ==== design/display_standby_power_manager.v ====
`include "standby_power_defs.vh"
module display_standby_power_manager
#(
    parameter DELAY_CYCLES  = `PANEL_DELAY_CYCLES,
    parameter MINUTE_CYCLES = `MINUTE_CYCLES
)
(
    input  wire        clk,
    input  wire        srst,
    input  wire [3:0]  addr,
    input  wire [7:0]  wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [7:0]  rdata,
    input  wire        standby_in,
    input  wire        ac_power_inhibit,
    input  wire        activity_in,
    input  wire        host_access,
    input  wire        keyboard_access,
    output reg         panel_logic_supply_en,
    output reg         panel_bias_supply_en,
    output reg         panel_backlight_en,
    output reg         panel_signals_en,
    output reg         video_clock_en,
    output reg         crt_clock_en,
    output reg         mclk_slow_en,
    output reg         dac_low_power,
    output reg         frame_accel_en,
    output reg         refresh_en,
    output reg         host_access_allowed,
    output reg         standby_active
);
    // State codes also appear in the status register
    localparam ST_OFF    = 3'd0;
    localparam ST_UP1    = 3'd1;
    localparam ST_UP2    = 3'd2;
    localparam ST_ON     = 3'd3;
    localparam ST_DN1    = 3'd4;
    localparam ST_DN2    = 3'd5;

    reg  [7:0]  ctrl;
    reg  [7:0]  reload;
    reg  [2:0]  state;
    reg  [31:0] delay_cnt;
    reg  [37:0] minute_cnt;
    reg  [3:0]  minutes_left;
    reg         timer_expired;
    reg  [2:0]  mclk_div;
    reg         standby_s1, standby_s2;
    reg         inhibit_s1, inhibit_s2;
    // Third activity flop exists only to find pin edges
    reg         act_s1, act_s2, act_s3;
    reg         host_s1, host_s2;
    reg         kbd_s1, kbd_s2;

    wire [3:0] timeout = ctrl[`TIMEOUT_MSB:`TIMEOUT_LSB];
    wire       ctrl_wr = wr && (addr == `REG_STANDBY_CTRL);
    wire       act_edge = act_s2 ^ act_s3;
    wire       reload_evt =
        (reload[`ACTIVITY_RELOAD_BIT] && act_edge) ||
        (reload[`HOST_RELOAD_BIT] && host_s2) ||
        (reload[`KEYBOARD_RELOAD_BIT] && kbd_s2);
    // Timer, software bit and pin are simply ORed
    wire       standby_req = timer_expired ||
                             ctrl[`SW_STANDBY_BIT] ||
                             standby_s2;
    wire       delay_done = (delay_cnt == 32'd0);

    // State decodes shared by the output registers
    function supply_on;
        input [2:0] s;
        begin
            supply_on = (s != ST_OFF);
        end
    endfunction

    function signals_on;
        input [2:0] s;
        begin
            signals_on = (s == ST_UP2) ||
                         (s == ST_ON) ||
                         (s == ST_DN1);
        end
    endfunction

    function lamps_on;
        input [2:0] s;
        begin
            lamps_on = (s == ST_ON);
        end
    endfunction

    function is_off;
        input [2:0] s;
        begin
            is_off = (s == ST_OFF);
        end
    endfunction

    function [31:0] delay_start;
        input dummy;
        begin
            delay_start = DELAY_CYCLES - 1;
        end
    endfunction

    // Pins are asynchronous to clk, so each passes two flops first
    always @(posedge clk)
    begin
        if (srst)
        begin
            standby_s1 <= 1'b0;
            standby_s2 <= 1'b0;
            inhibit_s1 <= 1'b0;
            inhibit_s2 <= 1'b0;
            act_s1     <= 1'b0;
            act_s2     <= 1'b0;
            act_s3     <= 1'b0;
            host_s1    <= 1'b0;
            host_s2    <= 1'b0;
            kbd_s1     <= 1'b0;
            kbd_s2     <= 1'b0;
        end
        else
        begin
            standby_s1 <= standby_in;
            standby_s2 <= standby_s1;
            inhibit_s1 <= ac_power_inhibit;
            inhibit_s2 <= inhibit_s1;
            act_s1     <= activity_in;
            act_s2     <= act_s1;
            act_s3     <= act_s2;
            host_s1    <= host_access;
            host_s2    <= host_s1;
            kbd_s1     <= keyboard_access;
            kbd_s2     <= kbd_s1;
        end
    end

    // Register file; contents survive standby untouched
    always @(posedge clk)
    begin
        if (srst)
        begin
            ctrl   <= `CTRL_RESET;
            reload <= `RELOAD_RESET;
        end
        else if (wr)
        begin
            if (addr == `REG_STANDBY_CTRL)
                ctrl <= wdata;
            else if (addr == `REG_RELOAD_CTRL)
                reload <= wdata;
        end
    end

    // Read data stands for one cycle, then returns to zero
    always @(posedge clk)
    begin
        if (srst)
            rdata <= 8'h00;
        else if (rd)
        begin
            case (addr)
                `REG_STANDBY_CTRL: rdata <= ctrl;
                `REG_RELOAD_CTRL:  rdata <= reload;
                `REG_STATUS:       rdata <= {minutes_left, timer_expired,
                                             state};
                default:           rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end

    // Standby timer: minute tick from the system clock
    always @(posedge clk)
    begin
        if (srst)
        begin
            minute_cnt    <= 38'd0;
            minutes_left  <= 4'd0;
            timer_expired <= 1'b0;
        end
        // A write wins, so a timeout set up from zero loads at once
        else if (ctrl_wr)
        begin
            minute_cnt    <= 38'd0;
            minutes_left  <= wdata[`TIMEOUT_MSB:`TIMEOUT_LSB];
            timer_expired <= 1'b0;
        end
        else if (timeout == 4'd0)
        begin
            minute_cnt    <= 38'd0;
            minutes_left  <= 4'd0;
            timer_expired <= 1'b0;
        end
        else if (reload_evt)
        begin
            minute_cnt    <= 38'd0;
            minutes_left  <= timeout;
            timer_expired <= 1'b0;
        end
        else if (inhibit_s2)
        begin
            minute_cnt    <= minute_cnt;
        end
        else if (!timer_expired)
        begin
            if (minute_cnt == MINUTE_CYCLES - 1)
            begin
                minute_cnt <= 38'd0;
                if (minutes_left <= 4'd1)
                begin
                    minutes_left  <= 4'd0;
                    timer_expired <= 1'b1;
                end
                else
                    minutes_left <= minutes_left - 4'd1;
            end
            else
                minute_cnt <= minute_cnt + 38'd1;
        end
    end

    // Panel sequencer; a running sequence always finishes first
    always @(posedge clk)
    begin
        if (srst)
        begin
            state     <= ST_UP1;
            delay_cnt <= delay_start(1'b0);
        end
        else
        begin
            case (state)
                ST_OFF:
                    if (!standby_req)
                    begin
                        state     <= ST_UP1;
                        delay_cnt <= DELAY_CYCLES - 1;
                    end
                ST_UP1:
                    if (delay_done)
                    begin
                        state     <= ST_UP2;
                        delay_cnt <= DELAY_CYCLES - 1;
                    end
                    else
                        delay_cnt <= delay_cnt - 32'd1;
                ST_UP2:
                    if (delay_done)
                        state <= ST_ON;
                    else
                        delay_cnt <= delay_cnt - 32'd1;
                // New requests are only looked at in ON and OFF
                ST_ON:
                    if (standby_req)
                    begin
                        state     <= ST_DN1;
                        delay_cnt <= DELAY_CYCLES - 1;
                    end
                ST_DN1:
                    if (delay_done)
                    begin
                        state     <= ST_DN2;
                        delay_cnt <= DELAY_CYCLES - 1;
                    end
                    else
                        delay_cnt <= delay_cnt - 32'd1;
                ST_DN2:
                    if (delay_done)
                        state <= ST_OFF;
                    else
                        delay_cnt <= delay_cnt - 32'd1;
                default:
                    state <= ST_OFF;
            endcase
        end
    end

    // Memory clock enable pulses once every six cycles in standby
    always @(posedge clk)
    begin
        if (srst)
            mclk_div <= 3'd0;
        else if (!standby_active || mclk_div == `MCLK_STANDBY_DIV - 1)
            mclk_div <= 3'd0;
        else
            mclk_div <= mclk_div + 3'd1;
    end

    // Panel rails and signals follow the sequencer state
    always @(posedge clk)
    begin
        if (srst)
        begin
            panel_logic_supply_en <= 1'b0;
            panel_bias_supply_en  <= 1'b0;
            panel_backlight_en    <= 1'b0;
            panel_signals_en      <= 1'b0;
        end
        else
        begin
            panel_logic_supply_en <= supply_on(state);
            panel_signals_en      <= signals_on(state);
            panel_bias_supply_en  <= lamps_on(state);
            panel_backlight_en    <= lamps_on(state);
        end
    end

    // Clock gating and DAC power track the standby state
    always @(posedge clk)
    begin
        if (srst)
        begin
            video_clock_en        <= 1'b0;
            crt_clock_en          <= 1'b0;
            mclk_slow_en          <= 1'b0;
            dac_low_power         <= 1'b0;
            standby_active        <= 1'b0;
        end
        else
        begin
            standby_active        <= is_off(state);
            video_clock_en        <= supply_on(state);
            crt_clock_en          <= supply_on(state);
            mclk_slow_en          <= supply_on(state) ||
                                     (mclk_div == 3'd0);
            dac_low_power         <= is_off(state);
        end
    end

    // Refresh and host access never stop, in normal mode or standby
    always @(posedge clk)
    begin
        if (srst)
        begin
            frame_accel_en        <= 1'b0;
            refresh_en            <= 1'b0;
            host_access_allowed   <= 1'b0;
        end
        else
        begin
            frame_accel_en        <= ctrl[`FRAME_ACCEL_BIT] &&
                                     ctrl[`DUAL_SCAN_BIT];
            refresh_en            <= 1'b1;
            host_access_allowed   <= 1'b1;
        end
    end
endmodule

// ==== design/standby_power_defs.vh ====
`ifndef STANDBY_POWER_DEFS_VH
`define STANDBY_POWER_DEFS_VH
// Register byte offsets
`define REG_STANDBY_CTRL     4'h0
`define REG_RELOAD_CTRL      4'h4
`define REG_STATUS           4'h8
// Standby control fields
`define TIMEOUT_LSB          0
`define TIMEOUT_MSB          3
`define SW_STANDBY_BIT       4
`define FRAME_ACCEL_BIT      5
`define DUAL_SCAN_BIT        6
// Reload control fields
`define HOST_RELOAD_BIT      5
`define ACTIVITY_RELOAD_BIT  6
`define KEYBOARD_RELOAD_BIT  7
// Reset values
`define CTRL_RESET           8'h00
`define RELOAD_RESET         8'h00
// Timing
`define CLK_HZ               100000000
`define PANEL_DELAY_MS       32
`define PANEL_DELAY_CYCLES   ((`PANEL_DELAY_MS * (`CLK_HZ / 1000)))
`define MINUTE_S             60
`define MINUTE_CYCLES        (`MINUTE_S * 38'h5f5_e100)
`define MCLK_STANDBY_DIV     6
`endif

// ==== tb/display_standby_power_manager_asserts.sv ====
module standby_checker
#(
    parameter int DELAY_CYCLES = 20
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic panel_logic_supply_en,
    input wire logic panel_bias_supply_en,
    input wire logic panel_backlight_en,
    input wire logic panel_signals_en,
    input wire logic video_clock_en,
    input wire logic crt_clock_en,
    input wire logic mclk_slow_en,
    input wire logic dac_low_power,
    input wire logic refresh_en,
    input wire logic host_access_allowed,
    input wire logic standby_active
);
    localparam int DLO = DELAY_CYCLES;
    localparam int DHI = DELAY_CYCLES + 2;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // Each panel step waits one full delay, with a little slack for lag
    sequence s_rise(s);
        ##[DLO:DHI] $rose(s);
    endsequence
    sequence s_fall(s);
        ##[DLO:DHI] $fell(s);
    endsequence
    property p_up_sig;
        $rose(panel_logic_supply_en) |-> s_rise(panel_signals_en);
    endproperty
    property p_up_bias;
        $rose(panel_signals_en) |-> s_rise(panel_bias_supply_en);
    endproperty
    property p_dn_sig;
        $fell(panel_bias_supply_en) |-> s_fall(panel_signals_en);
    endproperty
    property p_dn_sup;
        $fell(panel_signals_en) |-> s_fall(panel_logic_supply_en);
    endproperty
    property p_bl;
        panel_backlight_en == panel_bias_supply_en;
    endproperty
    property p_sb_clk;
        standby_active && $past(standby_active) |->
            !video_clock_en && !crt_clock_en && dac_low_power;
    endproperty
    property p_sb_mem;
        standby_active |-> refresh_en && host_access_allowed;
    endproperty
    property p_sb_panel;
        standby_active |-> !panel_logic_supply_en && !panel_signals_en;
    endproperty
    property p_mclk;
        mclk_slow_en && standby_active && $past(standby_active) |=>
            (!mclk_slow_en || !standby_active)[*5]
            ##1 (mclk_slow_en || !standby_active);
    endproperty
    property p_exit;
        $fell(standby_active) |-> ##[0:3] panel_logic_supply_en;
    endproperty
    a_up_sig: assert property (p_up_sig) else $error("early signals");
    a_up_bias: assert property (p_up_bias) else $error("early bias");
    a_dn_sig: assert property (p_dn_sig) else $error("signals off");
    a_dn_sup: assert property (p_dn_sup) else $error("supply off");
    a_bl: assert property (p_bl) else $error("backlight split");
    a_sb_clk: assert property (p_sb_clk) else $error("clocks on");
    a_sb_mem: assert property (p_sb_mem) else $error("refresh off");
    a_sb_panel: assert property (p_sb_panel) else $error("panel on");
    a_mclk: assert property (p_mclk) else $error("mclk ratio");
    a_exit: assert property (p_exit) else $error("no power-up");
endmodule

bind display_standby_power_manager standby_checker
    #(.DELAY_CYCLES(DELAY_CYCLES)) chk_u
(
    .clk, .srst, .panel_logic_supply_en, .panel_bias_supply_en,
    .panel_backlight_en, .panel_signals_en, .video_clock_en,
    .crt_clock_en, .mclk_slow_en, .dac_low_power, .refresh_en,
    .host_access_allowed, .standby_active
);

// ==== tb/panel_power_model.sv ====
module panel_power_model
(
    input  wire logic clk,
    input  wire logic req,
    input  wire logic panel_logic_supply_en,
    input  wire logic panel_bias_supply_en,
    input  wire logic panel_signals_en,
    output logic      standby_in,
    output logic      fault
);
    timeunit 1ns;
    timeprecision 1ps;
    initial standby_in = 0;
    initial fault = 0;
    // System logic holds the standby level until it drops it itself
    always @(posedge clk)
        standby_in <= req;
    // Bias or live signals on an unpowered panel would damage it
    always @(posedge clk)
        if (!panel_logic_supply_en && (panel_bias_supply_en || panel_signals_en))
            fault <= 1;
endmodule

// ==== tb/display_standby_power_manager_test.sv ====
module display_standby_power_manager_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, srst = 1, wr = 0, rd = 0, rd_q = 0, sb_req = 0;
    logic        ac_power_inhibit = 0, activity_in = 0;
    logic        host_access = 0, keyboard_access = 0;
    logic [3:0]  addr = 0;
    logic [7:0]  wdata = 0, d, rdata;
    logic        panel_logic_supply_en, panel_bias_supply_en;
    logic        panel_backlight_en, panel_signals_en, video_clock_en;
    logic        crt_clock_en, mclk_slow_en, dac_low_power, frame_accel_en;
    logic        refresh_en, host_access_allowed, standby_active;
    logic        standby_in, fault;
    logic [15:0] q[$];
    logic [15:0] n;
    int          err_count = 0, checks = 0, cyc = 0, i;
    always #5 clk = ~clk;
    display_standby_power_manager #(.DELAY_CYCLES(20), .MINUTE_CYCLES(50))
    dut_u
    (
        .clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .standby_in,
        .ac_power_inhibit, .activity_in, .host_access, .keyboard_access,
        .panel_logic_supply_en, .panel_bias_supply_en, .panel_backlight_en,
        .panel_signals_en, .video_clock_en, .crt_clock_en, .mclk_slow_en,
        .dac_low_power, .frame_accel_en, .refresh_en, .host_access_allowed,
        .standby_active
    );
    panel_power_model pm_u
    (
        .clk, .req(sb_req), .panel_logic_supply_en, .panel_bias_supply_en,
        .panel_signals_en, .standby_in, .fault
    );
    task close_out;
        $display("Compared %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task wreg(input logic [3:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
        @(posedge clk);
    endtask
    task rreg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        q.push_back({m, e});
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        @(posedge clk);
    endtask
    function logic [7:0] outs();
        return {video_clock_en, crt_clock_en, dac_low_power, refresh_en,
                host_access_allowed, panel_logic_supply_en,
                panel_signals_en, panel_backlight_en};
    endfunction
    function logic pick(input int sel);
        return sel ? panel_bias_supply_en : standby_active;
    endfunction
    task wait_lvl(input int sel, input logic v);
        for (int k = 0; k < 300 && pick(sel) !== v; k++)
            @(posedge clk);
        chk(8'(pick(sel)), 8'(v));
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        rd_q <= rd;
        if (rd_q)
        begin
            n = q.pop_front();
            chk(rdata & n[15:8], n[7:0]);
        end
        if (cyc == 20000)
        begin
            err_count++;
            $display("MISMATCH at %0t: run hung", $time);
            close_out;
        end
    end
    initial
    begin
        i = $urandom(32'h280e);
        repeat (12) @(posedge clk);
        srst <= 0;
        wait_lvl(1, 1);
        rreg(4'h8, 8'h03, 8'h07);
        rreg(4'h4, 8'h00, 8'hff);
        rreg(4'hc, 8'h00, 8'hff);
        chk(outs(), 8'hdf);
        for (i = 0; i < 4; i++)
        begin
            d = {1'b0, 2'(i), 5'h00};
            wreg(4'h0, d);
            rreg(4'h0, d, 8'hff);
            chk(8'(frame_accel_en), 8'(i == 3));
        end
        chk(8'(standby_active), 8'h00);
        d = 8'h10 | ($urandom & 8'h60);
        wreg(4'h0, d);
        wait_lvl(0, 1);
        chk(outs(), 8'h38);
        sb_req <= 1;
        // Pin request must be through its flops before software drops
        repeat (4) @(posedge clk);
        wreg(4'h0, d & 8'h60);
        repeat (30) @(posedge clk);
        chk(8'(standby_active), 8'h01);
        sb_req <= 0;
        wait_lvl(0, 0);
        wait_lvl(1, 1);
        rreg(4'h0, d & 8'h60, 8'hff);
        chk(outs(), 8'hdf);
        wreg(4'h0, 8'h10);
        repeat (5) @(posedge clk);
        wreg(4'h0, 8'h00);
        wait_lvl(0, 1);
        wait_lvl(1, 1);
        ac_power_inhibit <= 1;
        wreg(4'h4, 8'h40);
        wreg(4'h0, 8'h01);
        repeat (150) @(posedge clk);
        chk(8'(standby_active), 8'h00);
        ac_power_inhibit <= 0;
        for (i = 0; i < 4; i++)
        begin
            repeat (30) @(posedge clk);
            activity_in <= ~activity_in;
        end
        chk(8'(standby_active), 8'h00);
        wait_lvl(0, 1);
        rreg(4'h8, 8'h08, 8'h08);
        wreg(4'h0, 8'h00);
        wait_lvl(1, 1);
        for (i = 0; i < 2; i++)
        begin
            wreg(4'h4, i ? 8'h80 : 8'h20);
            wreg(4'h0, 8'h01);
            repeat (4)
            begin
                repeat (30) @(posedge clk);
                host_access <= (i == 0);
                keyboard_access <= (i == 1);
                repeat (3) @(posedge clk);
                host_access <= 0;
                keyboard_access <= 0;
            end
            chk(8'(standby_active), 8'h00);
            wreg(4'h0, 8'h00);
        end
        chk(8'(fault), 8'h00);
        close_out;
    end
endmodule
